// >>> design/dsrms_pkg.sv
package dsrms_pkg;

  // ------------------------------------------------------------
  // object indices
  // ------------------------------------------------------------
  localparam logic [15:0] IDX_QS_REACT   = 16'h605A; // quick_stop_reaction
  localparam logic [15:0] IDX_SD_REACT   = 16'h605B; // shutdown_reaction
  localparam logic [15:0] IDX_DO_REACT   = 16'h605C; // disable_operation_reaction
  localparam logic [15:0] IDX_HALT_REACT = 16'h605D; // halt_reaction
  localparam logic [15:0] IDX_FLT_REACT  = 16'h605E; // fault_reaction
  localparam logic [15:0] IDX_MODE_REQ   = 16'h6060; // operating_mode_request
  localparam logic [15:0] IDX_MODE_DISP  = 16'h6061; // operating_mode_display
  localparam logic [15:0] IDX_MODE_MASK  = 16'h6502; // supported_mode_mask

  // ------------------------------------------------------------
  // reset values and fixed contents
  // ------------------------------------------------------------
  localparam logic [15:0] QS_RESET    = 16'h0002;
  localparam logic [15:0] SD_RESET    = 16'h0000;
  localparam logic [15:0] DO_RESET    = 16'h0000;
  localparam logic [15:0] HALT_RESET  = 16'h0001;
  localparam logic [15:0] FLT_RESET   = 16'h0000;
  localparam logic [7:0]  MODE_RESET  = 8'h00;
  localparam logic [31:0] MODE_MASK   = 32'h0000_03ED;
  localparam logic [7:0]  MODE_MAX    = 8'h0A;
  localparam int          CW_HALT_BIT = 8;

  // ------------------------------------------------------------
  // option codes
  // ------------------------------------------------------------
  localparam logic [15:0] OPT_OFF      = 16'h0000; // power off, coast per stop method
  localparam logic [15:0] OPT_PROF     = 16'h0001; // profile decel, leave
  localparam logic [15:0] OPT_QSD      = 16'h0002; // quick stop decel, leave
  localparam logic [15:0] OPT_PROF_HLD = 16'h0005; // profile decel, stay
  localparam logic [15:0] OPT_QSD_HLD  = 16'h0006; // quick stop decel, stay

  // ------------------------------------------------------------
  // operating modes
  // ------------------------------------------------------------
  typedef enum logic [7:0] {
    MODE_NONE = 8'h00, MODE_PP  = 8'h01, MODE_PV  = 8'h03, MODE_PT  = 8'h04,
    MODE_HM   = 8'h06, MODE_IP  = 8'h07, MODE_CSP = 8'h08, MODE_CSV = 8'h09,
    MODE_CST  = 8'h0A
  } dsrms_mode_t;

  // stop kinds handed to the trajectory engine
  typedef enum logic [1:0] {
    STOP_NONE = 2'h0, STOP_OFF = 2'h1, STOP_PROF = 2'h3, STOP_QSD = 2'h2
  } dsrms_stop_t;

  // which stop-method parameter governs a coast stop
  typedef enum logic {
    METH_PRIMARY = 1'b0, METH_SECONDARY = 1'b1
  } dsrms_meth_t;

  // sequencer states, gray along idle -> stop -> done
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_STOP = 2'h1, ST_DONE = 2'h3, ST_HOLD = 2'h2
  } dsrms_state_t;

  // object access request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] index;
    logic [31:0] wdata;
  } dsrms_obj_req_t;

  // object access answer
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } dsrms_obj_rsp_t;

  // stop command to the motion side
  typedef struct packed {
    dsrms_stop_t kind;
    dsrms_meth_t meth;
    logic        power_off;
  } dsrms_stop_cmd_t;

  // whole module state
  typedef struct packed {
    logic [15:0]     qs;
    logic [15:0]     sd;
    logic [15:0]     dis;
    logic [15:0]     halt;
    logic [15:0]     flt;
    logic [7:0]      mode_req;
    logic [7:0]      mode_disp;
    dsrms_state_t    st;
    logic            to_qs_state;
    dsrms_stop_cmd_t cmd;
    dsrms_obj_rsp_t  rsp;
    logic [2:0]      alarm_sync;
  } dsrms_state_reg_t;

endpackage : dsrms_pkg

// >>> design/dsrms_ctrl.sv
// Overview of operation
// - quick stop code signed, 0/1/2/5/6, resets 2
// - code 0: power off, primary stop method
// - codes 1/2: ramp, then go disabled
// - codes 5/6: ramp, stay in quick stop
// - enabled-to-ready uses shutdown code 0/1
// - enabled-to-switched-on uses disable code, secondary
// - halt bit 8: profile or quick decel
// - alarm: power off per primary method in idle, hold or a ramping stop, not in done
// - mode request 0..10, resets 0, acted on
// - mode encoding with 2 and 5 unassigned
// - read-only mode display, resets 0
// - supported mask reads fixed 0x03ED
`timescale 1ns/10ps
`default_nettype none

module dsrms_ctrl (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // object access from the fieldbus side
  input  wire dsrms_pkg::dsrms_obj_req_t  obj_req,
  output var  dsrms_pkg::dsrms_obj_rsp_t  obj_rsp,
  // drive state machine events, one-cycle pulses
  input  wire logic                       ev_quick_stop,
  input  wire logic                       ev_shutdown,
  input  wire logic                       ev_disable_op,
  input  wire logic [15:0]                controlword,
  // alarm from the protection logic, asynchronous
  input  wire logic                       alarm_pin,
  // motion side status
  input  wire logic                       axis_at_rest,
  input  wire logic [7:0]                 loop_mode_active,
  // outputs to motion and state machine
  output var  dsrms_pkg::dsrms_stop_cmd_t stop_cmd,
  output logic                            qs_leave_to_disabled,
  output logic                            qs_stay_active,
  output logic [7:0]                      mode_request
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  dsrms_pkg::dsrms_state_reg_t s_q;   // registered state
  dsrms_pkg::dsrms_state_reg_t s_d;   // next state

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // legal quick stop code check
  function automatic logic qs_ok(input logic [15:0] v);
    qs_ok = (v == dsrms_pkg::OPT_OFF) || (v == dsrms_pkg::OPT_PROF) ||
            (v == dsrms_pkg::OPT_QSD) || (v == dsrms_pkg::OPT_PROF_HLD) ||
            (v == dsrms_pkg::OPT_QSD_HLD);
  endfunction : qs_ok

  // legal mode code: only assigned codes are taken
  function automatic logic mode_ok(input logic [7:0] v);
    mode_ok = (v <= dsrms_pkg::MODE_MAX) &&
              (v != 8'h02) && (v != 8'h05);
  endfunction : mode_ok

  logic alarm_now;  // synchronised alarm level
  logic halt_on;    // halt bit of the controlword

  assign alarm_now = s_q.alarm_sync[1] & s_q.alarm_sync[2];
  assign halt_on   = controlword[dsrms_pkg::CW_HALT_BIT];

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    logic [15:0] wv;  // write value, low half
    wv   = obj_req.wdata[15:0];
    s_d  = s_q;
    // answer lasts one cycle
    s_d.rsp.ack   = 1'b0;
    s_d.rsp.err   = 1'b0;
    s_d.rsp.rdata = 32'h0000_0000;
    // alarm: three flops, level high only while the last two are both high
    s_d.alarm_sync = {s_q.alarm_sync[1:0], alarm_pin};
    // display tracks the loop only once it has really switched
    if (loop_mode_active == s_q.mode_req) begin
      s_d.mode_disp = loop_mode_active;
    end

    // object writes
    if (obj_req.wr) begin
      s_d.rsp.ack = 1'b1;
      unique case (obj_req.index)
        dsrms_pkg::IDX_QS_REACT: begin
          if (qs_ok(wv)) s_d.qs = wv;
          else s_d.rsp.err = 1'b1;
        end
        dsrms_pkg::IDX_SD_REACT: begin
          if (wv <= dsrms_pkg::OPT_PROF) s_d.sd = wv;
          else s_d.rsp.err = 1'b1;
        end
        dsrms_pkg::IDX_DO_REACT: begin
          if (wv <= dsrms_pkg::OPT_PROF) s_d.dis = wv;
          else s_d.rsp.err = 1'b1;
        end
        dsrms_pkg::IDX_HALT_REACT: begin
          if (wv == dsrms_pkg::OPT_PROF || wv == dsrms_pkg::OPT_QSD) begin
            s_d.halt = wv;
          end else begin
            s_d.rsp.err = 1'b1;
          end
        end
        dsrms_pkg::IDX_FLT_REACT: begin
          // only power-off exists, so other codes bounce
          if (wv == dsrms_pkg::OPT_OFF) s_d.flt = wv;
          else s_d.rsp.err = 1'b1;
        end
        dsrms_pkg::IDX_MODE_REQ: begin
          if (obj_req.wdata[31:8] == 24'h00_0000 && mode_ok(obj_req.wdata[7:0])) begin
            s_d.mode_req = obj_req.wdata[7:0];
          end else begin
            s_d.rsp.err = 1'b1;
          end
        end
        // read-only and unknown objects refuse writes
        default: s_d.rsp.err = 1'b1;
      endcase
    end else if (obj_req.rd) begin
      s_d.rsp.ack = 1'b1;
      unique case (obj_req.index)
        // signed objects sign-extend into the word
        dsrms_pkg::IDX_QS_REACT:   s_d.rsp.rdata = {{16{s_q.qs[15]}}, s_q.qs};
        dsrms_pkg::IDX_SD_REACT:   s_d.rsp.rdata = {{16{s_q.sd[15]}}, s_q.sd};
        dsrms_pkg::IDX_DO_REACT:   s_d.rsp.rdata = {{16{s_q.dis[15]}}, s_q.dis};
        dsrms_pkg::IDX_HALT_REACT: s_d.rsp.rdata = {{16{s_q.halt[15]}}, s_q.halt};
        dsrms_pkg::IDX_FLT_REACT:  s_d.rsp.rdata = {{16{s_q.flt[15]}}, s_q.flt};
        dsrms_pkg::IDX_MODE_REQ:   s_d.rsp.rdata = {24'h00_0000, s_q.mode_req};
        dsrms_pkg::IDX_MODE_DISP:  s_d.rsp.rdata = {24'h00_0000, s_q.mode_disp};
        dsrms_pkg::IDX_MODE_MASK:  s_d.rsp.rdata = dsrms_pkg::MODE_MASK;
        default:                   s_d.rsp.err   = 1'b1;
      endcase
    end

    // stop sequencer; the alarm wins in idle, hold and a ramping stop, but not in done
    unique case (s_q.st)
      dsrms_pkg::ST_IDLE: begin
        s_d.cmd = '{kind: dsrms_pkg::STOP_NONE, meth: dsrms_pkg::METH_PRIMARY,
                    power_off: 1'b0};
        s_d.to_qs_state = 1'b0;
        if (alarm_now) begin
          s_d.cmd = '{kind: dsrms_pkg::STOP_OFF, meth: dsrms_pkg::METH_PRIMARY,
                      power_off: 1'b1};
          s_d.st  = dsrms_pkg::ST_STOP;
        end else if (ev_quick_stop) begin
          s_d.st = dsrms_pkg::ST_STOP;
          unique case (s_q.qs)
            dsrms_pkg::OPT_PROF: s_d.cmd.kind = dsrms_pkg::STOP_PROF;
            dsrms_pkg::OPT_QSD:  s_d.cmd.kind = dsrms_pkg::STOP_QSD;
            dsrms_pkg::OPT_PROF_HLD: begin
              s_d.cmd.kind    = dsrms_pkg::STOP_PROF;
              s_d.to_qs_state = 1'b1;
            end
            dsrms_pkg::OPT_QSD_HLD: begin
              s_d.cmd.kind    = dsrms_pkg::STOP_QSD;
              s_d.to_qs_state = 1'b1;
            end
            default: begin
              s_d.cmd.kind      = dsrms_pkg::STOP_OFF;
              s_d.cmd.power_off = 1'b1;
            end
          endcase
        end else if (ev_shutdown) begin
          s_d.st = dsrms_pkg::ST_STOP;
          if (s_q.sd == dsrms_pkg::OPT_PROF) begin
            s_d.cmd.kind = dsrms_pkg::STOP_PROF;
          end else begin
            s_d.cmd.kind      = dsrms_pkg::STOP_OFF;
            s_d.cmd.power_off = 1'b1;
          end
        end else if (ev_disable_op) begin
          s_d.st = dsrms_pkg::ST_STOP;
          if (s_q.dis == dsrms_pkg::OPT_PROF) begin
            s_d.cmd.kind = dsrms_pkg::STOP_PROF;
          end else begin
            s_d.cmd = '{kind: dsrms_pkg::STOP_OFF,
                        meth: dsrms_pkg::METH_SECONDARY, power_off: 1'b1};
          end
        end else if (halt_on) begin
          // halt ramps but never cuts power; it lasts while the bit is set
          s_d.cmd.kind = (s_q.halt == dsrms_pkg::OPT_QSD) ?
                         dsrms_pkg::STOP_QSD : dsrms_pkg::STOP_PROF;
          s_d.st = dsrms_pkg::ST_HOLD;
        end
      end
      dsrms_pkg::ST_STOP: begin
        // alarm during a ramp turns it into a power-off stop
        if (alarm_now && !s_q.cmd.power_off) begin
          s_d.cmd = '{kind: dsrms_pkg::STOP_OFF, meth: dsrms_pkg::METH_PRIMARY,
                      power_off: 1'b1};
          s_d.to_qs_state = 1'b0;
        end else if (axis_at_rest) begin
          s_d.st = dsrms_pkg::ST_DONE;
        end
      end
      dsrms_pkg::ST_DONE: begin
        // a held quick stop stays here until released; otherwise stay while the alarm is present
        // a held quick stop is released by a fresh quick stop pulse
        if (!s_q.to_qs_state && !alarm_now) s_d.st = dsrms_pkg::ST_IDLE;
        else if (s_q.to_qs_state && ev_quick_stop) s_d.st = dsrms_pkg::ST_IDLE;
      end
      dsrms_pkg::ST_HOLD: begin
        if (alarm_now) begin
          s_d.cmd = '{kind: dsrms_pkg::STOP_OFF, meth: dsrms_pkg::METH_PRIMARY,
                      power_off: 1'b1};
          s_d.st  = dsrms_pkg::ST_STOP;
        end else if (!halt_on) begin
          s_d.st = dsrms_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // ------------------------------------------------------------
  // register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q.qs          <= dsrms_pkg::QS_RESET;
      s_q.sd          <= dsrms_pkg::SD_RESET;
      s_q.dis         <= dsrms_pkg::DO_RESET;
      s_q.halt        <= dsrms_pkg::HALT_RESET;
      s_q.flt         <= dsrms_pkg::FLT_RESET;
      s_q.mode_req    <= dsrms_pkg::MODE_RESET;
      s_q.mode_disp   <= dsrms_pkg::MODE_RESET;
      s_q.st          <= dsrms_pkg::ST_IDLE;
      s_q.to_qs_state <= 1'b0;
      s_q.cmd         <= '{kind: dsrms_pkg::STOP_NONE,
                           meth: dsrms_pkg::METH_PRIMARY, power_off: 1'b0};
      s_q.rsp         <= '{ack: 1'b0, err: 1'b0, rdata: 32'h0000_0000};
      s_q.alarm_sync  <= 3'h0;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign obj_rsp  = s_q.rsp;
  assign stop_cmd = s_q.cmd;
  // end-of-stop hints to the drive state machine
  assign qs_leave_to_disabled = (s_q.st == dsrms_pkg::ST_DONE) && !s_q.to_qs_state;
  assign qs_stay_active       = (s_q.st == dsrms_pkg::ST_DONE) && s_q.to_qs_state;
  assign mode_request         = s_q.mode_req;

endmodule : dsrms_ctrl

`default_nettype wire

// >>> verif/dsrms_ctrl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module dsrms_ctrl_monitor (
  // clock and reset
  input wire logic                       ref_clk,
  input wire logic                       rst,
  // object channel
  input wire dsrms_pkg::dsrms_obj_req_t  obj_req,
  input wire dsrms_pkg::dsrms_obj_rsp_t  obj_rsp,
  // stop side
  input wire logic                       alarm_pin,
  input wire dsrms_pkg::dsrms_stop_cmd_t stop_cmd,
  input wire logic                       qs_leave_to_disabled,
  input wire logic                       qs_stay_active,
  input wire logic [7:0]                 mode_request
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic        take; // any access taken this edge
  logic        mwr;  // write to the mode request
  logic [31:0] wd;   // write data shorthand
  assign take = obj_req.rd | obj_req.wr;
  assign mwr  = obj_req.wr && obj_req.index == dsrms_pkg::IDX_MODE_REQ;
  assign wd   = obj_req.wdata;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_ack; take |=> obj_rsp.ack; endproperty
  a_ack: assert property (p_ack) else $error("access not answered");
  property p_quiet; !take |=> !obj_rsp.ack; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without access");
  property p_mask;
    obj_req.rd && !obj_req.wr && obj_req.index == dsrms_pkg::IDX_MODE_MASK
      |=> obj_rsp.rdata == dsrms_pkg::MODE_MASK && !obj_rsp.err;
  endproperty
  a_mask: assert property (p_mask) else $error("mode mask read wrong");
  property p_ro;
    obj_req.wr && (obj_req.index == dsrms_pkg::IDX_MODE_DISP ||
                   obj_req.index == dsrms_pkg::IDX_MODE_MASK) |=> obj_rsp.err;
  endproperty
  a_ro: assert property (p_ro) else $error("read-only write accepted");
  property p_qs_bad;
    obj_req.wr && obj_req.index == dsrms_pkg::IDX_QS_REACT &&
      !(wd[15:0] inside {16'h0, 16'h1, 16'h2, 16'h5, 16'h6}) |=> obj_rsp.err;
  endproperty
  a_qs_bad: assert property (p_qs_bad) else $error("bad stop code accepted");
  property p_mode_bad;
    mwr && (wd == 32'h2 || wd == 32'h5 || wd > 32'hA) |=> obj_rsp.err && $stable(mode_request);
  endproperty
  a_mode_bad: assert property (p_mode_bad) else $error("bad mode accepted");
  property p_mode_ok;
    mwr && wd <= 32'hA && wd != 32'h2 && wd != 32'h5
      |=> !obj_rsp.err && mode_request == $past(wd[7:0]);
  endproperty
  a_mode_ok: assert property (p_mode_ok) else $error("mode not stored");
  property p_alarm;
    alarm_pin [*5] |-> stop_cmd.kind == dsrms_pkg::STOP_OFF && stop_cmd.power_off &&
      stop_cmd.meth == dsrms_pkg::METH_PRIMARY;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm did not cut power");
  property p_leave; qs_leave_to_disabled |=> !qs_leave_to_disabled && !qs_stay_active; endproperty
  a_leave: assert property (p_leave) else $error("leave hint not a pulse");
endmodule : dsrms_ctrl_monitor
bind dsrms_ctrl dsrms_ctrl_monitor i_dsrms_ctrl_monitor (.ref_clk(ref_clk), .rst(rst),
  .obj_req(obj_req), .obj_rsp(obj_rsp), .alarm_pin(alarm_pin), .stop_cmd(stop_cmd),
  .qs_leave_to_disabled(qs_leave_to_disabled), .qs_stay_active(qs_stay_active),
  .mode_request(mode_request));
`default_nettype wire

// >>> verif/dsrms_host.sv
`timescale 1ns/10ps
`default_nettype none
// host model: one object access at a time, request for one cycle
module dsrms_host (
  // clock
  input  wire logic                      ref_clk,
  // object channel
  output var  dsrms_pkg::dsrms_obj_req_t obj_req,
  input  wire dsrms_pkg::dsrms_obj_rsp_t obj_rsp
);
  initial obj_req = '0;
  // caller keeps mode writes within 0..10 unless a refusal is wanted
  task automatic access(input logic w, input logic [15:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd, output logic e);
    int n;
    obj_req = {~w, w, idx, wd};
    @(posedge ref_clk);
    #1;
    // released lines show inverted data so stale values never look valid
    obj_req = {1'b0, 1'b0, ~idx, ~wd};
    for (n = 0; n < 3; n++) begin
      if (obj_rsp.ack === 1'b1) break;
      @(posedge ref_clk);
      #1;
    end
    rd = obj_rsp.rdata;
    e = ~obj_rsp.ack | obj_rsp.err;
    // let an edge pass so the next request never lands in this time step
    @(posedge ref_clk);
    #1;
  endtask : access
endmodule : dsrms_host
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic                       ref_clk, rst, alarm_pin, axis_at_rest, er, saw_leave, saw_stay;
  logic [2:0]                 evs;  // quick stop, shutdown, disable
  logic [15:0]                controlword;
  logic [7:0]                 loop_mode_active, mode_request;
  logic [31:0]                rd;
  dsrms_pkg::dsrms_obj_req_t  obj_req;
  dsrms_pkg::dsrms_obj_rsp_t  obj_rsp;
  dsrms_pkg::dsrms_stop_cmd_t stop_cmd;
  logic                       qs_leave_to_disabled, qs_stay_active;
  int                         error_cnt, checked, cyc;
  dsrms_ctrl i_dsrms_ctrl (.ref_clk(ref_clk), .rst(rst), .obj_req(obj_req), .obj_rsp(obj_rsp),
    .ev_quick_stop(evs[2]), .ev_shutdown(evs[1]), .ev_disable_op(evs[0]),
    .controlword(controlword), .alarm_pin(alarm_pin), .axis_at_rest(axis_at_rest),
    .loop_mode_active(loop_mode_active), .stop_cmd(stop_cmd),
    .qs_leave_to_disabled(qs_leave_to_disabled), .qs_stay_active(qs_stay_active),
    .mode_request(mode_request));
  dsrms_host i_dsrms_host (.ref_clk(ref_clk), .obj_req(obj_req), .obj_rsp(obj_rsp));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic test_done;
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one access; read data only judged on an accepted read
  task automatic acc(input logic w, input logic [15:0] idx, input logic [31:0] wd,
                     input logic ee, input logic [31:0] ed);
    i_dsrms_host.access(w, idx, wd, rd, er);
    chk({31'h0, er}, {31'h0, ee});
    if (!w && !ee) chk(rd, ed);
  endtask : acc
  // store a code, trigger a stop, wait for the command, then let the axis rest
  task automatic stopseq(input logic [2:0] e, input logic h, input logic [15:0] idx,
                         input logic [15:0] code, input logic [3:0] exp, input logic [3:0] m);
    int n;
    acc(1'b1, idx, {16'h0, code}, 1'b0, 32'h0);
    saw_leave = 1'b0;
    saw_stay = 1'b0;
    controlword[8] = h;
    evs = e;
    @(posedge ref_clk);
    #1;
    evs = 3'h0;
    for (n = 0; n < 6 && (stop_cmd & m) !== exp; n++) begin
      @(posedge ref_clk);
      #1;
    end
    chk({28'h0, stop_cmd & m}, {28'h0, exp});
    axis_at_rest = 1'b1;
    for (n = 0; n < 5; n++) begin
      @(posedge ref_clk);
      #1;
      saw_leave |= qs_leave_to_disabled === 1'b1;
      saw_stay |= qs_stay_active === 1'b1;
    end
    controlword = 16'h0;
    axis_at_rest = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : stopseq
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [15:0] ix [8] = '{16'h605A, 16'h605B, 16'h605C, 16'h605D, 16'h605E, 16'h6060,
                            16'h6061, 16'h6502};
    logic [31:0] rv [8] = '{32'h2, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h3ED};
    for (int i = 0; i < 8; i++) acc(1'b0, ix[i], 32'h0, 1'b0, rv[i]);
    acc(1'b0, 16'h6062, 32'h0, 1'b1, 32'h0);
  endtask : t_reset
  task automatic t_codes;
    logic ok;
    for (int v = 0; v < 8; v++) acc(1'b1, 16'h605A, v, !(v inside {0, 1, 2, 5, 6}), 0);
    acc(1'b1, 16'h605A, 32'hFFFF, 1'b1, 32'h0);
    acc(1'b0, 16'h605A, 32'h0, 1'b0, 32'h6);
    acc(1'b1, 16'h605B, 32'h2, 1'b1, 32'h0);
    acc(1'b1, 16'h605C, 32'h2, 1'b1, 32'h0);
    acc(1'b1, 16'h605D, 32'h0, 1'b1, 32'h0);
    acc(1'b1, 16'h605E, 32'h1, 1'b1, 32'h0);
    acc(1'b1, 16'h6061, 32'h1, 1'b1, 32'h0);
    acc(1'b1, 16'h6502, 32'h0, 1'b1, 32'h0);
    for (int v = 0; v < 12; v++) begin
      ok = v <= 10 && v != 2 && v != 5;
      acc(1'b1, 16'h6060, v, !ok, 32'h0);
      if (ok) chk({24'h0, mode_request}, v);
    end
    acc(1'b0, 16'h6061, 32'h0, 1'b0, 32'h0);
    loop_mode_active = 8'h0A;
    repeat (2) @(posedge ref_clk);
    #1;
    acc(1'b0, 16'h6061, 32'h0, 1'b0, 32'hA);
  endtask : t_codes
  task automatic t_quick;
    logic [15:0] cd [5] = '{16'h0, 16'h1, 16'h2, 16'h5, 16'h6};
    logic [3:0]  ex [5] = '{4'h5, 4'hC, 4'h8, 4'hC, 4'h8};
    for (int i = 0; i < 5; i++) begin
      stopseq(3'h4, 1'b0, 16'h605A, cd[i], ex[i], i ? 4'hD : 4'hF);
      if (i) chk({31'h0, saw_leave}, {31'h0, cd[i] < 3});
      if (i) chk({31'h0, saw_stay}, {31'h0, cd[i] > 3});
      if (cd[i] > 3) begin
        evs = 3'h4;
        @(posedge ref_clk);
        #1;
        evs = 3'h0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk({31'h0, qs_stay_active}, 32'h0);
      end
    end
  endtask : t_quick
  task automatic t_other;
    stopseq(3'h2, 1'b0, 16'h605B, 16'h1, 4'hC, 4'hD);
    stopseq(3'h2, 1'b0, 16'h605B, 16'h0, 4'h5, 4'hF);
    stopseq(3'h1, 1'b0, 16'h605C, 16'h1, 4'hC, 4'hD);
    stopseq(3'h1, 1'b0, 16'h605C, 16'h0, 4'h7, 4'hF);
    stopseq(3'h0, 1'b1, 16'h605D, 16'h1, 4'hC, 4'hD);
    stopseq(3'h0, 1'b1, 16'h605D, 16'h2, 4'h8, 4'hD);
    alarm_pin = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    chk({28'h0, stop_cmd}, 32'h5);
  endtask : t_other
  // ----------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    {rst, alarm_pin, axis_at_rest, evs, controlword, loop_mode_active} = {1'b1, 29'h0};
    repeat (5) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    @(posedge ref_clk);
    #1;
    t_reset();
    t_codes();
    t_quick();
    t_other();
    test_done();
  end
endmodule : testbench
`default_nettype wire
